/* logic/tsr_pkg.sv */
// constants and types for the tdm time-slot router
package tsr_pkg;
  localparam int TBL_DEPTH = 64;
  localparam int ENT_W = 16;
  localparam int MAX_FRAME_BITS = 8192;
  localparam int FRM_W = 13;
  localparam int E_LOOP = 15;
  localparam int E_SWAP = 14;
  localparam int E_STB_LO = 10;
  localparam int E_CH_LO = 6;
  localparam int E_LEN_LO = 2;
  localparam int E_BYTE = 1;
  localparam int E_LAST = 0;
  localparam logic [7:0] A_TX_BASE = 8'h00;
  localparam logic [7:0] A_RX_BASE = 8'h40;
  localparam logic [7:0] A_MODE = 8'h80;
  localparam logic [7:0] A_ROUTE = 8'h81;
  localparam logic [7:0] A_SWAP = 8'h82;
  localparam logic [7:0] A_FRM0 = 8'h83;
  localparam logic [7:0] A_FRM1 = 8'h84;
  localparam int M_EN_LO = 0;
  localparam int M_TWO = 2;
  localparam int M_DYN = 3;
  localparam int M_ECHO_LO = 4;
  localparam int M_LOOP_LO = 6;
  localparam logic [2:0] CH_FIRST = 3'h1;
  localparam logic [2:0] CH_LAST = 3'h6;
  localparam logic [5:0] HW1_BASE = 6'h20;
  localparam logic [5:0] FULL_MASK = 6'h3f;
  typedef enum logic [1:0] {
    W_IDLE = 2'b00,
    W_RUN = 2'b01,
    W_ERR = 2'b10
  } tsr_wstate_t;
endpackage : tsr_pkg

/* logic/tsr_router.sv */
// time-slot router: two highways, table walkers, register port
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module tsr_router
  import tsr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdData,
  input wire logic [1:0] hwClk,
  input wire logic [1:0] hwSync,
  input wire logic [1:0] hwRxData,
  output logic [1:0] hwTxData,
  output logic [1:0] hwTxOe_n,
  output logic [3:0] strobe,
  input wire logic [5:0] chTxBit,
  output logic [5:0] chTxTake,
  output logic [5:0] chRxBit,
  output logic [5:0] chRxValid,
  input wire logic [5:0] dedRxPin,
  output logic [5:0] dedTxPin
);

  typedef struct packed {
    logic [TBL_DEPTH-1:0][ENT_W-1:0] txMem;
    logic [TBL_DEPTH-1:0][ENT_W-1:0] rxMem;
    logic [1:0] hwEn;
    logic [1:0] echo;
    logic [1:0] loopMode;
    logic [1:0] swapReq;
    logic [1:0] half;
    logic twoHw;
    logic dyn;
    logic [5:0] chRoute;
    logic [1:0] clkS1;
    logic [1:0] clkS2;
    logic [1:0] clkPrev;
    logic [1:0] syncS1;
    logic [1:0] syncS2;
    logic [1:0] syncPrev;
    logic [1:0] rxS1;
    logic [1:0] rxS2;
    logic [5:0] dedS1;
    logic [5:0] dedS2;
    tsr_wstate_t [3:0] ws;
    logic [3:0][5:0] ptr;
    logic [3:0][3:0] unitCnt;
    logic [3:0][2:0] bitIdx;
    logic [3:0][3:0] stbW;
    logic [1:0][FRM_W-1:0] frm;
    logic [1:0] txData;
    logic [1:0] txOe_n;
    logic [3:0] strobe;
    logic [5:0] chRx;
    logic [5:0] chRxValid;
    logic [5:0] chTxTake;
    logic [5:0] dedTx;
    logic [15:0] rdData;
  } tsr_state_t;

  tsr_state_t st_ff;
  tsr_state_t nxt_st;
  logic [1:0] tick;
  logic [1:0] fs;
  logic [1:0] swapNow;
  logic [1:0] swapSet;
  logic [3:0] act;
  logic [3:0] lastDone;
  logic [3:0][15:0] ent;
  logic [1:0][5:0] rxTo;
  logic [5:0] mask;
  logic [5:0] base;
  logic [5:0] po;
  logic [3:0] uc;
  logic [2:0] bi;
  logic [2:0] cs;
  logic [2:0] idx;
  logic run;
  logic lastBit;
  logic rxBit;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.chRxValid = 6'h00;
    nxt_st.chTxTake = 6'h00;
    nxt_st.rdData = 16'h0000;
    swapSet = 2'b00;
    act = 4'h0;
    lastDone = 4'h0;
    ent = '0;
    rxTo = '0;
    base = 6'h00;
    po = 6'h00;
    uc = 4'h0;
    bi = 3'h0;
    cs = 3'h0;
    idx = 3'h0;
    run = 1'b0;
    lastBit = 1'b0;
    rxBit = 1'b0;
    // highway inputs cross in through two flops before anything reads them
    nxt_st.clkS1 = hwClk;
    nxt_st.clkS2 = st_ff.clkS1;
    nxt_st.clkPrev = st_ff.clkS2;
    nxt_st.syncS1 = hwSync;
    nxt_st.syncS2 = st_ff.syncS1;
    nxt_st.rxS1 = hwRxData;
    nxt_st.rxS2 = st_ff.rxS1;
    nxt_st.dedS1 = dedRxPin;
    nxt_st.dedS2 = st_ff.dedS1;
    // register port
    if (regWr) begin
      if (regAddr < A_RX_BASE) begin
        nxt_st.txMem[regAddr[5:0]] = regWrData;
      end else if (regAddr < A_MODE) begin
        nxt_st.rxMem[regAddr[5:0]] = regWrData;
      end else begin
        case (regAddr)
          A_MODE: begin
            nxt_st.hwEn = regWrData[M_EN_LO +: 2];
            nxt_st.twoHw = regWrData[M_TWO];
            nxt_st.dyn = regWrData[M_DYN];
            nxt_st.echo = regWrData[M_ECHO_LO +: 2];
            nxt_st.loopMode = regWrData[M_LOOP_LO +: 2];
          end
          A_ROUTE: nxt_st.chRoute = regWrData[5:0];
          A_SWAP: swapSet = regWrData[1:0];
          default: ;
        endcase
      end
    end
    if (regRd) begin
      if (regAddr < A_RX_BASE) begin
        nxt_st.rdData = st_ff.txMem[regAddr[5:0]];
      end else if (regAddr < A_MODE) begin
        nxt_st.rdData = st_ff.rxMem[regAddr[5:0]];
      end else begin
        case (regAddr)
          A_MODE: nxt_st.rdData = {8'h00, st_ff.loopMode, st_ff.echo, st_ff.dyn, st_ff.twoHw, st_ff.hwEn};
          A_ROUTE: nxt_st.rdData = {10'h000, st_ff.chRoute};
          A_SWAP: nxt_st.rdData = {4'h0, st_ff.ws, st_ff.half, st_ff.swapReq};
          A_FRM0: nxt_st.rdData = {3'h0, st_ff.frm[0]};
          A_FRM1: nxt_st.rdData = {3'h0, st_ff.frm[1]};
          default: nxt_st.rdData = 16'h0000;
        endcase
      end
    end
    // each highway advances only on its own synchronised clock edge
    for (int h = 0; h < 2; h++) begin
      tick[h] = st_ff.clkS2[h] & ~st_ff.clkPrev[h] & st_ff.hwEn[h];
      fs[h] = tick[h] & st_ff.syncS2[h] & ~st_ff.syncPrev[h];
      if (tick[h]) begin
        nxt_st.syncPrev[h] = st_ff.syncS2[h];
      end
      swapNow[h] = fs[h] & st_ff.swapReq[h] & st_ff.dyn;
      if (swapNow[h]) begin
        nxt_st.half[h] = ~st_ff.half[h];
      end
      if (!st_ff.hwEn[h]) begin
        nxt_st.frm[h] = '0;
      end else if (tick[h]) begin
        if (fs[h]) begin
          nxt_st.frm[h] = FRM_W'(1);
        end else if (st_ff.frm[h] != FRM_W'(MAX_FRAME_BITS - 1)) begin
          nxt_st.frm[h] = FRM_W'(st_ff.frm[h] + FRM_W'(1));
        end
      end
    end
    // software set beats the hardware clear in the same cycle
    nxt_st.swapReq = (st_ff.swapReq & ~swapNow) | swapSet;
    // region size shrinks by half per highway split and per shadow split
    mask = FULL_MASK >> ({1'b0, st_ff.twoHw} + {1'b0, st_ff.dyn});
    // walker w: bit 1 is the highway, bit 0 picks receive over transmit
    for (int w = 0; w < 4; w++) begin
      base = ((st_ff.twoHw && w >= 2) ? HW1_BASE : 6'h00)
           | ((st_ff.dyn && nxt_st.half[w/2]) ? 6'(mask + 6'h01) : 6'h00);
      run = 1'b0;
      po = st_ff.ptr[w];
      uc = st_ff.unitCnt[w];
      bi = st_ff.bitIdx[w];
      if (!st_ff.hwEn[w/2]) begin
        nxt_st.ws[w] = W_IDLE;
        nxt_st.ptr[w] = 6'h00;
        nxt_st.unitCnt[w] = 4'h0;
        nxt_st.bitIdx[w] = 3'h0;
        nxt_st.stbW[w] = 4'h0;
      end else if (tick[w/2]) begin
        if (fs[w/2]) begin
          po = 6'h00;
          uc = 4'h0;
          bi = 3'h0;
          if (st_ff.ws[w] == W_RUN) begin
            nxt_st.ws[w] = W_ERR;
          end else begin
            nxt_st.ws[w] = W_RUN;
            run = 1'b1;
          end
        end else begin
          run = (st_ff.ws[w] == W_RUN);
        end
        ent[w] = w[0] ? st_ff.rxMem[base | (po & mask)] : st_ff.txMem[base | (po & mask)];
        if (run) begin
          act[w] = 1'b1;
          lastBit = !ent[w][E_BYTE] || bi == 3'h7;
          bi = ent[w][E_BYTE] ? 3'(bi + 3'h1) : 3'h0;
          if (lastBit) begin
            if (uc == ent[w][E_LEN_LO +: 4]) begin
              uc = 4'h0;
              if (ent[w][E_LAST]) begin
                lastDone[w] = 1'b1;
                nxt_st.ws[w] = W_IDLE;
                po = 6'h00;
              end else begin
                po = (po + 6'h01) & mask;
              end
            end else begin
              uc = 4'(uc + 4'h1);
            end
          end
        end
        nxt_st.ptr[w] = po;
        nxt_st.unitCnt[w] = uc;
        nxt_st.bitIdx[w] = bi;
        nxt_st.stbW[w] = run ? ent[w][E_STB_LO +: 4] : 4'h0;
      end
    end
    // dedicated pins serve every channel not handed to the router
    for (int c = 0; c < 6; c++) begin
      if (!st_ff.chRoute[c]) begin
        nxt_st.chRx[c] = st_ff.dedS2[c];
      end
      nxt_st.dedTx[c] = st_ff.chRoute[c] ? 1'b0 : chTxBit[c];
    end
    for (int h = 0; h < 2; h++) begin
      cs = ent[2*h][E_CH_LO +: 3];
      idx = 3'(cs - 3'h1);
      if (!st_ff.hwEn[h]) begin
        nxt_st.txOe_n[h] = 1'b1;
        nxt_st.txData[h] = 1'b0;
      end else if (tick[h]) begin
        nxt_st.txOe_n[h] = 1'b1;
        nxt_st.txData[h] = 1'b0;
        if (st_ff.echo[h]) begin
          nxt_st.txData[h] = st_ff.rxS2[h];
          nxt_st.txOe_n[h] = 1'b0;
        end else if (act[2*h] && cs >= CH_FIRST && cs <= CH_LAST && st_ff.chRoute[idx]) begin
          nxt_st.txData[h] = chTxBit[idx];
          nxt_st.txOe_n[h] = 1'b0;
          nxt_st.chTxTake[idx] = 1'b1;
        end
      end
      cs = ent[2*h+1][E_CH_LO +: 3];
      idx = 3'(cs - 3'h1);
      // per-entry loop bit or highway loopback takes the bit just sent
      rxBit = (st_ff.loopMode[h] || ent[2*h+1][E_LOOP]) ? nxt_st.txData[h] : st_ff.rxS2[h];
      if (tick[h] && act[2*h+1] && cs >= CH_FIRST && cs <= CH_LAST && st_ff.chRoute[idx]) begin
        rxTo[h][idx] = 1'b1;
        nxt_st.chRx[idx] = rxBit;
        nxt_st.chRxValid[idx] = 1'b1;
      end
    end
    // shared strobes are the or of every walker that selects them
    nxt_st.strobe = nxt_st.stbW[0] | nxt_st.stbW[1] | nxt_st.stbW[2] | nxt_st.stbW[3];
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.txOe_n <= 2'b11;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign regRdData = st_ff.rdData;
  assign hwTxData = st_ff.txData;
  assign hwTxOe_n = st_ff.txOe_n;
  assign strobe = st_ff.strobe;
  assign chTxTake = st_ff.chTxTake;
  assign chRxBit = st_ff.chRx;
  assign chRxValid = st_ff.chRxValid;
  assign dedTxPin = st_ff.dedTx;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  disabled_quiet_a: assert property (
    !st_ff.hwEn[0] |=> hwTxOe_n[0] && st_ff.ws[0] == W_IDLE && st_ff.ptr[0] == 6'h00 && st_ff.stbW[0] == 4'h0)
    else $error("disabled highway not quiet");

  swap_at_sync_a: assert property (
    swapNow[0] && !(regWr && regAddr == A_SWAP) |=> st_ff.half[0] != $past(st_ff.half[0]) && !st_ff.swapReq[0])
    else $error("swap not taken at frame sync");

  early_sync_abort_a: assert property (
    st_ff.ws[1] == W_RUN && fs[0] |=> st_ff.ws[1] == W_ERR ##1 (st_ff.ws[1] == W_ERR || fs[0]) [*1])
    else $error("early sync did not abort walk");

  final_stop_a: assert property (
    lastDone[0] |=> st_ff.ws[0] == W_IDLE && st_ff.ptr[0] == 6'h00)
    else $error("walk kept going past final entry");

  echo_whole_a: assert property (
    tick[0] && st_ff.echo[0] |=> !hwTxOe_n[0] && hwTxData[0] == $past(st_ff.rxS2[0]))
    else $error("echo did not return received bit");

  loopback_a: assert property (
    tick[0] && st_ff.loopMode[0] && rxTo[0] != 6'h00
      |=> (chRxBit & $past(rxTo[0])) == ($past(nxt_st.txData[0]) ? $past(rxTo[0]) : 6'h00))
    else $error("loopback bit mismatch");

  strobe_follow_a: assert property (
    tick[1] && act[2] |=> (strobe & $past(ent[2][E_STB_LO +: 4])) == $past(ent[2][E_STB_LO +: 4]))
    else $error("strobe not asserted for entry");

  // a layout change while highway 1 runs is not guarded; the host disables it first
  region_bound_a: assert property (
    st_ff.hwEn[1] && st_ff.twoHw |-> st_ff.ptr[3] <= (st_ff.dyn ? 6'h0f : 6'h1f))
    else $error("pointer left its partition");

  channel_select_a: assert property (
    (st_ff.chRoute == 6'h00) |=> chRxValid == 6'h00 && chTxTake == 6'h00)
    else $error("unrouted channel saw router traffic");

  // codes 0 and 7 must leave the line free for other transmitters
  unrouted_quiet_a: assert property (
    tick[0] && !st_ff.echo[0] && act[0] && (ent[0][E_CH_LO +: 3] == 3'h0 || ent[0][E_CH_LO +: 3] == 3'h7)
      |=> hwTxOe_n[0])
    else $error("unrouted group drove the highway");

  hw_off_quiet_a: assert property (
    !st_ff.hwEn[1] |=> hwTxOe_n[1] && st_ff.stbW[2] == 4'h0 && st_ff.stbW[3] == 4'h0)
    else $error("disabled highway carried traffic");

  swap_cover_c: cover property (swapNow[0] ##1 st_ff.ws[0] == W_RUN);
  abort_cover_c: cover property (st_ff.ws[0] == W_ERR ##[1:200] st_ff.ws[0] == W_RUN);
  last_cover_c: cover property (lastDone[1] ##[1:50] fs[0]);
  two_hw_cover_c: cover property (act[0] && act[2]);

endmodule : tsr_router
`default_nettype wire

/* tb/test_tsr_router.sv */
// self-checking bench for the tdm time-slot router
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); n_errors++; end end
module test_tsr_router
  import tsr_pkg::*;
;
  logic ref_clk, rst_n, regWr, regRd, clr;
  logic [7:0] regAddr;
  logic [15:0] regWrData, regRdData, v;
  logic [1:0] hwTxData, hwTxOe_n, go, rxLv, oeSeen;
  // framer outputs are nets: each framer instance drives one bit of them
  wire logic [1:0] hwClk, hwSync, hwRxData, busy;
  logic [3:0] strobe, stbSeen;
  logic [5:0] chTxBit, chTxTake, chRxBit, chRxValid, dedRxPin, dedTxPin;
  logic [13:0] nb, rs;
  int n_errors, cmp_count, lbBad, ones, zeros;
  int tk[6];
  int vd[6];

  tsr_router dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .hwClk(hwClk), .hwSync(hwSync), .hwRxData(hwRxData),
    .hwTxData(hwTxData), .hwTxOe_n(hwTxOe_n), .strobe(strobe), .chTxBit(chTxBit), .chTxTake(chTxTake),
    .chRxBit(chRxBit), .chRxValid(chRxValid), .dedRxPin(dedRxPin), .dedTxPin(dedTxPin));
  for (genvar h = 0; h < 2; h++) begin : g_hw
    tsr_hw_framer fr (.start(go[h]), .nBits(nb), .reSync(rs), .rxLevel(rxLv[h]), .hwClk(hwClk[h]),
      .hwSync(hwSync[h]), .hwRxData(hwRxData[h]), .busy(busy[h]));
  end

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // event tallies per frame; non-blocking so the main sequence never races them
  always @(posedge ref_clk) begin
    for (int c = 0; c < 6; c++) begin
      tk[c] <= clr ? 0 : tk[c] + int'(chTxTake[c]);
      vd[c] <= clr ? 0 : vd[c] + int'(chRxValid[c]);
    end
    lbBad <= clr ? 0 : lbBad + int'(|(chRxValid & ~chRxBit));
    ones <= clr ? 0 : ones + int'(!hwTxOe_n[0] && hwTxData[0]);
    zeros <= clr ? 0 : zeros + int'(!hwTxOe_n[0] && !hwTxData[0]);
    stbSeen <= clr ? 4'h0 : stbSeen | strobe;
    oeSeen <= clr ? 2'h0 : oeSeen | ~hwTxOe_n;
  end

  task automatic tally_and_finish;
    $display("counts: compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
    @(posedge ref_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 v = regRdData;
    @(posedge ref_clk);
  endtask : rd

  function automatic logic [15:0] ent(input logic [2:0] ch, input logic [3:0] len, input logic byt, final_entry_bit,
      input logic [3:0] stb);
    return {2'b00, stb, 1'b0, ch, len, byt, final_entry_bit};
  endfunction : ent

  task automatic frame(input logic [1:0] w, input logic [13:0] n, input logic [13:0] r);
    int k;
    nb <= n;
    rs <= r;
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    go <= w;
    @(posedge ref_clk);
    go <= 2'b00;
    for (k = 0; k < 4000 && busy !== 2'b00; k++) @(posedge ref_clk);
    if (busy !== 2'b00) begin
      n_errors++;
      tally_and_finish();
    end
    // tick detection lags the pin by a few core cycles
    repeat (8) @(posedge ref_clk);
  endtask : frame

  initial begin
    rst_n = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWrData = 16'h0000;
    chTxBit = 6'h00;
    dedRxPin = 6'h15;
    go = 2'b00;
    rxLv = 2'b00;
    nb = 14'd0;
    rs = 14'd0;
    clr = 1'b0;
    n_errors = 0;
    cmp_count = 0;
    repeat (4) @(posedge ref_clk);
    `CHK("oe in reset", 2'b11, hwTxOe_n)
    `CHK("strobe in reset", 4'h0, strobe)
    rst_n <= 1'b1;
    @(posedge ref_clk);
    wr(A_TX_BASE + 8'h3f, 16'hbeef);
    wr(A_RX_BASE + 8'h3f, 16'h1234);
    rd(A_TX_BASE + 8'h3f);
    `CHK("tx word 63", 16'hbeef, v)
    rd(A_RX_BASE + 8'h3f);
    `CHK("rx word 63", 16'h1234, v)
    rd(8'h90);
    `CHK("unmapped read", 16'h0000, v)
    $display("test registers done");
    `CHK("dedicated rx", 6'h15, chRxBit)
    chTxBit <= 6'h21;
    wr(A_ROUTE, 16'h001f);
    repeat (2) @(posedge ref_clk);
    `CHK("dedicated pins", 6'h20, dedTxPin)
    $display("test channel select done");
    // every channel code once; codes 3 and 7 in bytes, code 7 closes the table
    for (int i = 0; i < 8; i++) begin
      v = ent(3'(i), (i == 3) ? 4'h1 : 4'h0, i == 3 || i == 7, i == 7, 4'(1 << (i % 4)));
      wr(A_TX_BASE + 8'(i), v);
      wr(A_RX_BASE + 8'(i), v);
    end
    wr(A_ROUTE, 16'h003f);
    frame(2'b11, 14'd34, 14'd0);
    `CHK("disabled oe", 2'b00, oeSeen)
    `CHK("disabled takes", 0, tk[1])
    wr(A_MODE, 16'h0001);
    frame(2'b11, 14'd34, 14'd0);
    for (int c = 0; c < 6; c++) begin
      `CHK("tx takes", (c == 2) ? 16 : 1, tk[c])
      `CHK("rx valids", (c == 2) ? 16 : 1, vd[c])
    end
    `CHK("strobes seen", 4'hf, stbSeen)
    `CHK("strobes idle", 4'h0, strobe)
    `CHK("hw1 stays off", 2'b01, oeSeen)
    rd(A_FRM0);
    `CHK("frame bits", 16'h0022, v)
    rd(A_FRM1);
    `CHK("hw1 frame bits", 16'h0000, v)
    $display("test static walk done");
    wr(A_MODE, 16'h0041);
    rd(A_MODE);
    `CHK("mode readback", 16'h0041, v)
    chTxBit <= 6'h3f;
    frame(2'b01, 14'd34, 14'd0);
    `CHK("loop bits", 0, lbBad)
    `CHK("loop valids", 1, vd[0])
    $display("test loopback done");
    wr(A_MODE, 16'h0011);
    chTxBit <= 6'h00;
    rxLv <= 2'b01;
    frame(2'b01, 14'd34, 14'd0);
    `CHK("echo ones", 1, ones > 0)
    chTxBit <= 6'h3f;
    rxLv <= 2'b00;
    frame(2'b01, 14'd34, 14'd0);
    `CHK("echo zeros", 1, zeros > 0)
    $display("test echo done");
    wr(A_MODE, 16'h0001);
    wr(A_TX_BASE, ent(3'h2, 4'hf, 1'b0, 1'b1, 4'h1));
    frame(2'b01, 14'd24, 14'd8);
    `CHK("early sync cut", 8, tk[1])
    rd(A_SWAP);
    `CHK("walker error", 2'h2, v[5:4])
    frame(2'b01, 14'd16, 14'd0);
    `CHK("resumed", 16, tk[1])
    $display("test early sync done");
    wr(A_TX_BASE, ent(3'h2, 4'h0, 1'b0, 1'b1, 4'h1));
    wr(A_TX_BASE + 8'h20, ent(3'h4, 4'h0, 1'b0, 1'b1, 4'h2));
    wr(A_MODE, 16'h0009);
    frame(2'b01, 14'd4, 14'd0);
    `CHK("active half", 1, tk[1])
    `CHK("shadow quiet", 0, tk[3])
    wr(A_SWAP, 16'h0001);
    rd(A_SWAP);
    `CHK("swap pending", 1'b1, v[0])
    frame(2'b01, 14'd4, 14'd0);
    `CHK("swapped", 1, tk[3])
    rd(A_SWAP);
    `CHK("swap done", 2'b10, {v[2], v[0]})
    $display("test shadow swap done");
    wr(A_MODE, 16'h0007);
    frame(2'b11, 14'd4, 14'd0);
    `CHK("hw0 route", 1, tk[1])
    `CHK("hw1 route", 1, tk[3])
    `CHK("both driving", 2'b11, oeSeen)
    $display("test two highways done");
    tally_and_finish();
  end
endmodule : test_tsr_router
`default_nettype wire

/* tb/tsr_hw_framer.sv */
// highway framer model: gated link clock, frame sync and receive data
`timescale 1ns/10ps
`default_nettype none
module tsr_hw_framer (
  input wire logic start,
  input wire logic [13:0] nBits,
  input wire logic [13:0] reSync,
  input wire logic rxLevel,
  output logic hwClk,
  output logic hwSync,
  output logic hwRxData,
  output logic busy
);
  initial begin
    hwClk = 1'b0;
    hwSync = 1'b0;
    hwRxData = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge start);
      busy = 1'b1;
      #37;
      for (int i = 0; i < nBits; i++) begin
        hwSync = (i == 0) || (i == reSync);
        hwRxData = rxLevel;
        #160 hwClk = 1'b1;
        #160 hwClk = 1'b0;
      end
      // clock stands low between frames; released data line has no pull, so flip it
      hwSync = 1'b0;
      hwRxData = ~hwRxData;
      busy = 1'b0;
    end
  end
endmodule : tsr_hw_framer
`default_nettype wire
